// ==== rtl/sdram_cmd_if.v ====
// Command, control and address front end of a registered memory module.
// Assumes all inputs but the asynchronous reset nrst synchronous to clk; the host obeys command timing.
`default_nettype none
`include "sdram_cmd_map.vh"

// Function
// - Strobes plus chip select define the command each clock.
// - Chip select high masks all commands; it is part of code.
// - Clock gate high runs; low gives power-down or self refresh with all banks closed, suspend during a burst.
// - Clock gate synchronous except while in power-down or self refresh.
// - Read lanes with mask high go high impedance two clocks later.
// - Bank select picks bank for ACTIVE, READ, WRITE, PRECHARGE.
// - Address gives row with ACTIVE, column with READ or WRITE.
// - Address bit 10 is auto precharge for READ and WRITE.
// - PRECHARGE with bit 10 low hits one bank, high hits all.
// - Mode register set loads the address as op-code.
// - Bank select chooses normal or extended mode register.
// - Register mode delays control and address by one clock.
// - Bursts of 1, 2, 4, 8 or full page, with terminate.
module sdram_cmd_if
(
  input  wire                  clk,
  input  wire                  nrst,
  input  wire                  chip_select_n_lo,
  input  wire                  chip_select_n_hi,
  input  wire                  ras_n,
  input  wire                  cas_n,
  input  wire                  we_n,
  input  wire                  clock_gate_in,
  input  wire [`LANES-1:0]     byte_mask_lanes,
  input  wire                  bank_select_0,
  input  wire                  bank_select_1,
  input  wire [`ADDR_W-1:0]    addr,
  input  wire                  register_mode_select,
  output reg  [3:0]            bank_open_r,
  output reg  [`ADDR_W-1:0]    access_row_r,
  output reg  [`COL_W-1:0]     access_col_r,
  output reg  [`BANK_W-1:0]    access_bank_r,
  output reg                   auto_precharge_r,
  output reg                   burst_active_r,
  output reg                   burst_is_write_r,
  output reg  [`LANES-1:0]     write_lane_en_r,
  output reg  [`LANES-1:0]     read_drive_en_r,
  output reg  [`ADDR_W-1:0]    mode_reg_r,
  output reg  [`ADDR_W-1:0]    ext_mode_reg_r,
  output reg                   power_down_r,
  output reg                   self_refresh_r,
  output reg                   clock_suspend_r,
  output wire                  input_buf_en,
  output reg                   refresh_pulse_r,
  output reg                   protocol_err_r
);

  // ==========================================================
  // Helpers
  // ==========================================================
  function [11:0] burst_len;
    input [2:0] code;
    begin
      case (code)
        `BL_1:    burst_len = 12'h001;
        `BL_2:    burst_len = 12'h002;
        `BL_4:    burst_len = 12'h004;
        `BL_8:    burst_len = 12'h008;
        `BL_PAGE: burst_len = `PAGE_LEN;
        default:  burst_len = 12'h001;
      endcase
    end
  endfunction

  function [3:0] bank_onehot;
    input [1:0] b;
    begin
      bank_onehot = 4'h1 << b;
    end
  endfunction

  // ==========================================================
  // Input stage: registered or buffered
  // ==========================================================
  localparam ST_RUN = 3'h1;
  localparam ST_PD  = 3'h2;
  localparam ST_SR  = 3'h4;

  reg  [2:0]          state_r;
  reg  [2:0]          state_nxt;
  reg  [3:0]          cmd_q_r;
  reg  [`BANK_W-1:0]  ba_q_r;
  reg  [`ADDR_W-1:0]  addr_q_r;
  reg                 cke_q_r;
  reg                 cke_prev_r;
  wire                cs_n_in;
  wire [3:0]          cmd_in;
  wire [3:0]          cmd_s;
  wire [`BANK_W-1:0]  ba_s;
  wire [`ADDR_W-1:0]  addr_s;
  wire                cke_s;
  wire                asleep;

  assign asleep       = state_r != ST_RUN;
  // Both rank selects tie to the same rank; either low enables it
  assign cs_n_in      = chip_select_n_lo & chip_select_n_hi;
  // Dead buffers read as NOP so nothing decodes while asleep
  assign input_buf_en = ~asleep;
  assign cmd_in       = input_buf_en ? {cs_n_in, ras_n, cas_n, we_n}
                                     : `CMD_NOP;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_q_r  <= `CMD_NOP;
      ba_q_r   <= 2'h0;
      addr_q_r <= 13'h0000;
      cke_q_r  <= 1'b1;
    end
    else
    begin
      cmd_q_r  <= cmd_in;
      ba_q_r   <= {bank_select_1, bank_select_0};
      addr_q_r <= addr;
      cke_q_r  <= clock_gate_in;
    end
  end

  assign cmd_s  = register_mode_select ? cmd_q_r : cmd_in;
  assign ba_s   = register_mode_select ? ba_q_r
                                       : {bank_select_1, bank_select_0};
  assign addr_s = register_mode_select ? addr_q_r : addr;
  assign cke_s  = register_mode_select ? cke_q_r : clock_gate_in;

  wire is_mrs;
  wire is_ref;
  wire is_pre;
  wire is_act;
  wire is_wr;
  wire is_rd;
  wire is_bst;

  cmd_decode u_dec
  (
    .cs_n   (cmd_s[3]),
    .ras_n  (cmd_s[2]),
    .cas_n  (cmd_s[1]),
    .we_n   (cmd_s[0]),
    .is_mrs (is_mrs),
    .is_ref (is_ref),
    .is_pre (is_pre),
    .is_act (is_act),
    .is_wr  (is_wr),
    .is_rd  (is_rd),
    .is_bst (is_bst)
  );

  // Commands only act when the clock was enabled in the prior cycle
  wire run = (state_r == ST_RUN) & cke_prev_r;

  // ==========================================================
  // Power states
  // ==========================================================
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (cke_prev_r && !cke_s && !burst_active_r && bank_open_r == 4'h0)
          state_nxt = is_ref ? ST_SR : ST_PD;
      ST_PD:
        // Gate is watched directly, not through the input register
        if (clock_gate_in)
          state_nxt = ST_RUN;
      ST_SR:
        if (clock_gate_in)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r         <= ST_RUN;
      cke_prev_r      <= 1'b1;
      power_down_r    <= 1'b0;
      self_refresh_r  <= 1'b0;
      clock_suspend_r <= 1'b0;
    end
    else
    begin
      state_r         <= state_nxt;
      cke_prev_r      <= (state_nxt == ST_RUN) ? cke_s : 1'b0;
      power_down_r    <= state_nxt == ST_PD;
      self_refresh_r  <= state_nxt == ST_SR;
      clock_suspend_r <= (state_nxt == ST_RUN) & ~cke_s
                         & burst_active_r;
    end
  end

  // ==========================================================
  // Bank, address and burst tracking
  // ==========================================================
  reg  [11:0] burst_left_r;
  wire [11:0] new_len = burst_len(mode_reg_r[`MR_BL_MSB:`MR_BL_LSB]);
  wire        col_cmd = run & (is_rd | is_wr);
  wire [3:0]  pre_mask = addr_s[`AP_BIT] ? 4'hf : bank_onehot(ba_s);
  // Auto precharge closes its bank even under a concurrent command
  wire [3:0]  ap_close = (burst_active_r && cke_prev_r && auto_precharge_r
                          && burst_left_r == 12'h001) ?
                         bank_onehot(access_bank_r) : 4'h0;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bank_open_r      <= 4'h0;
      access_row_r     <= 13'h0000;
      access_col_r     <= 11'h000;
      access_bank_r    <= 2'h0;
      auto_precharge_r <= 1'b0;
      burst_active_r   <= 1'b0;
      burst_is_write_r <= 1'b0;
      burst_left_r     <= 12'h000;
      mode_reg_r       <= `MR_RESET;
      ext_mode_reg_r   <= `EMR_RESET;
      refresh_pulse_r  <= 1'b0;
      protocol_err_r   <= 1'b0;
    end
    else
    begin
      // Refresh with the gate low enters self refresh, not auto refresh
      refresh_pulse_r <= run & is_ref & cke_s;
      if (run & is_act)
      begin
        bank_open_r   <= (bank_open_r & ~ap_close) | bank_onehot(ba_s);
        access_bank_r <= ba_s;
        access_row_r  <= addr_s;
      end
      else if (run & is_pre)
        bank_open_r <= bank_open_r & ~pre_mask & ~ap_close;
      else
        bank_open_r <= bank_open_r & ~ap_close;
      if (col_cmd)
      begin
        // Host must have opened the row first; flag it if not
        if (!bank_open_r[ba_s])
          protocol_err_r <= 1'b1;
        access_bank_r    <= ba_s;
        access_col_r     <= {addr_s[11], addr_s[9:0]};
        auto_precharge_r <= addr_s[`AP_BIT];
        burst_active_r   <= 1'b1;
        burst_is_write_r <= is_wr;
        burst_left_r     <= new_len;
      end
      else if (run & (is_bst | is_pre))
      begin
        burst_active_r <= 1'b0;
        burst_left_r   <= 12'h000;
      end
      else if (burst_active_r && cke_prev_r)
      begin
        // Full page wraps and runs until terminated
        if (burst_left_r == 12'h001 &&
            mode_reg_r[`MR_BL_MSB:`MR_BL_LSB] != `BL_PAGE)
          burst_active_r <= 1'b0;
        else if (burst_left_r == 12'h001)
          burst_left_r <= `PAGE_LEN;
        else
          burst_left_r <= burst_left_r - 12'h001;
      end
      if (run & is_mrs)
      begin
        if (ba_s == `MR_SEL_EXT)
          ext_mode_reg_r <= addr_s;
        else if (ba_s == `MR_SEL_NORM)
          mode_reg_r <= addr_s;
      end
    end
  end

  // ==========================================================
  // Byte masks
  // ==========================================================
  reg [`LANES-1:0] rd_mask_d1_r;
  genvar g;
  generate
    for (g = 0; g < `LANES; g = g + 1)
    begin : g_lane
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          write_lane_en_r[g] <= 1'b0;
          rd_mask_d1_r[g]    <= 1'b1;
          read_drive_en_r[g] <= 1'b0;
        end
        else
        begin
          // Write data for a masked lane is dropped in that cycle
          write_lane_en_r[g] <= burst_is_write_r & burst_active_r
                                & ~byte_mask_lanes[g];
          // Two stages give the two-clock read mask latency
          rd_mask_d1_r[g]    <= byte_mask_lanes[g];
          read_drive_en_r[g] <= ~burst_is_write_r & burst_active_r
                                & ~rd_mask_d1_r[g];
        end
      end
    end
  endgenerate

endmodule // sdram_cmd_if

`default_nettype wire

// ==== rtl/sdram_cmd_map.vh ====
// Constants for the module command interface: command codes, field
// positions, mode register layout and latency figures.
// Assumes inclusion by plain Verilog-2005 design files.
`ifndef SDRAM_CMD_MAP_VH
`define SDRAM_CMD_MAP_VH

// Command code {cs_n, ras_n, cas_n, we_n}
`define CMD_MRS      4'h0
`define CMD_REF      4'h1
`define CMD_PRE      4'h2
`define CMD_ACT      4'h3
`define CMD_WR       4'h4
`define CMD_RD       4'h5
`define CMD_BST      4'h6
`define CMD_NOP      4'h7

// Address fields
`define ADDR_W       13
`define BANK_W       2
`define LANES        8
`define AP_BIT       10
`define COL_W        11

// Mode register fields
`define MR_BL_LSB    0
`define MR_BL_MSB    2
`define MR_BT_BIT    3
`define MR_CL_LSB    4
`define MR_CL_MSB    6
`define MR_RESET     13'h0030
`define EMR_RESET    13'h0000
`define MR_SEL_NORM  2'h0
`define MR_SEL_EXT   2'h2

// Burst length codes and full page length
`define BL_1         3'h0
`define BL_2         3'h1
`define BL_4         3'h2
`define BL_8         3'h3
`define BL_PAGE      3'h7
`define PAGE_LEN     12'h800

// Read mask to high impedance latency in clocks
`define DQM_RD_LAT   2

`endif

// ==== rtl/cmd_decode.v ====
// Command decoder: turns the strobe combination into one-hot commands.
// Assumes the strobes are already synchronous to the module clock.
`default_nettype none
`include "sdram_cmd_map.vh"

module cmd_decode
(
  input  wire       cs_n,
  input  wire       ras_n,
  input  wire       cas_n,
  input  wire       we_n,
  output wire       is_mrs,
  output wire       is_ref,
  output wire       is_pre,
  output wire       is_act,
  output wire       is_wr,
  output wire       is_rd,
  output wire       is_bst
);

  wire [3:0] code;

  // Chip select high masks every command, so it forms the top code bit
  assign code   = {cs_n, ras_n, cas_n, we_n};
  assign is_mrs = (code == `CMD_MRS);
  assign is_ref = (code == `CMD_REF);
  assign is_pre = (code == `CMD_PRE);
  assign is_act = (code == `CMD_ACT);
  assign is_wr  = (code == `CMD_WR);
  assign is_rd  = (code == `CMD_RD);
  assign is_bst = (code == `CMD_BST);

endmodule // cmd_decode

`default_nettype wire

// ==== testbench/cmd_if_asserts.sv ====
// Checker for the command front end of the memory module.
// Sees only the top ports; bound to sdram_cmd_if below.
`default_nettype none
`include "sdram_cmd_map.vh"
module cmd_if_asserts
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        chip_select_n_lo,
  input wire logic        chip_select_n_hi,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        clock_gate_in,
  input wire logic [7:0]  byte_mask_lanes,
  input wire logic        bank_select_0,
  input wire logic        bank_select_1,
  input wire logic [12:0] addr,
  input wire logic        register_mode_select,
  input wire logic [3:0]  bank_open_r,
  input wire logic [12:0] access_row_r,
  input wire logic [7:0]  read_drive_en_r,
  input wire logic [12:0] mode_reg_r,
  input wire logic [12:0] ext_mode_reg_r,
  input wire logic        power_down_r,
  input wire logic        self_refresh_r,
  input wire logic        input_buf_en,
  input wire logic        refresh_pulse_r
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [3:0] cmd;
  wire logic [1:0] bk;
  wire logic       go;
  logic            g_r;
  assign cmd = {chip_select_n_lo & chip_select_n_hi, ras_n, cas_n, we_n};
  assign bk = {bank_select_1, bank_select_0};
  // Only buffered-mode commands with a steady gate are judged here
  assign go = g_r && clock_gate_in && !register_mode_select
              && !power_down_r && !self_refresh_r;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      g_r <= 1'b0;
    else
      g_r <= clock_gate_in && !register_mode_select;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_cs_masks: assert property (go && cmd[3] |=>
    $stable({mode_reg_r, ext_mode_reg_r})) else $error("deselect loaded");
  a_mrs_norm: assert property (go && cmd == `CMD_MRS && bk == 2'h0
    |=> mode_reg_r == $past(addr)) else $error("mode load wrong");
  a_mrs_ext: assert property (go && cmd == `CMD_MRS && bk == 2'h2
    |=> ext_mode_reg_r == $past(addr)) else $error("ext load wrong");
  a_act_open: assert property (go && cmd == `CMD_ACT |=>
    bank_open_r[$past(bk)] && access_row_r == $past(addr))
    else $error("activate wrong");
  a_pre_all: assert property (go && cmd == `CMD_PRE && addr[10]
    |=> bank_open_r == 4'h0) else $error("precharge all wrong");
  a_pre_one: assert property (go && cmd == `CMD_PRE && !addr[10]
    |=> !bank_open_r[$past(bk)]) else $error("precharge one wrong");
  a_rd_hiz: assert property (byte_mask_lanes != 8'h00
    && !register_mode_select |-> ##2
    (read_drive_en_r & $past(byte_mask_lanes, 2)) == 8'h00)
    else $error("masked lane still driven");
  a_buf_off: assert property (input_buf_en ==
    !(power_down_r || self_refresh_r)) else $error("buffer enable wrong");
  a_ref_cause: assert property (refresh_pulse_r |->
    $past(go && cmd == `CMD_REF)) else $error("stray refresh pulse");
endmodule // cmd_if_asserts
bind sdram_cmd_if cmd_if_asserts cmd_if_asserts_inst (.*);
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host controller model: one command per call, deselect after it.
// Assumes calls are made between clock edges of clk.
`default_nettype none
module host_model
(
  input  wire logic        clk,
  output var  logic        chip_select_n_lo,
  output var  logic        chip_select_n_hi,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic        clock_gate_in,
  output var  logic [7:0]  byte_mask_lanes,
  output var  logic        bank_select_0,
  output var  logic        bank_select_1,
  output var  logic [12:0] addr,
  output var  logic        register_mode_select
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {chip_select_n_lo, chip_select_n_hi, ras_n, cas_n, we_n} = 5'h1f;
    clock_gate_in = 1'b1;
    byte_mask_lanes = 8'h00;
    {bank_select_1, bank_select_0} = 2'h0;
    addr = 13'h0000;
    register_mode_select = 1'b0;
  end
  // Idle address is inverted so stale lines never look like the last one
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                     input logic [12:0] a, input logic hi, input logic g);
    @(posedge clk);
    chip_select_n_lo <= c[3] | hi;
    chip_select_n_hi <= c[3] | !hi;
    {ras_n, cas_n, we_n} <= c[2:0];
    {bank_select_1, bank_select_0} <= b;
    addr <= a;
    clock_gate_in <= g;
    @(posedge clk);
    {chip_select_n_lo, chip_select_n_hi, ras_n, cas_n, we_n} <= 5'h1f;
    addr <= ~a;
  endtask
  task automatic lvl(input logic g, input logic [7:0] m, input logic r);
    @(posedge clk);
    clock_gate_in <= g;
    byte_mask_lanes <= m;
    register_mode_select <= r;
  endtask
endmodule // host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the command front end.
// Assumes host_model and the bound checker are compiled first.
`default_nettype none
`include "sdram_cmd_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire logic chip_select_n_lo, chip_select_n_hi, ras_n, cas_n, we_n;
  wire logic clock_gate_in, bank_select_0, bank_select_1;
  wire logic register_mode_select;
  wire logic [7:0] byte_mask_lanes;
  wire logic [12:0] addr;
  logic [3:0] bank_open_r;
  logic [12:0] access_row_r, mode_reg_r, ext_mode_reg_r;
  logic [10:0] access_col_r;
  logic [1:0] access_bank_r;
  logic [7:0] write_lane_en_r, read_drive_en_r;
  logic auto_precharge_r, burst_active_r, burst_is_write_r;
  logic power_down_r, self_refresh_r, clock_suspend_r;
  logic input_buf_en, refresh_pulse_r, protocol_err_r;
  int error_cnt = 0;
  int n_compared = 0;
  always #2 clk = ~clk;
  sdram_cmd_if sdram_cmd_if_inst (.*);
  host_model host_model_inst (.*);
  // ==========================================
  // Helpers
  task automatic chk(input logic [12:0] e, input logic [12:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic nx(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic cm(input logic [3:0] k, input logic [1:0] b,
                    input logic [12:0] a);
    host_model_inst.cmd(k, b, a, 1'b0, 1'b1);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_mrs;
    nx(0);
    chk(13'h0030, mode_reg_r);
    chk(13'h0001, input_buf_en);
    cm(`CMD_MRS, 2'h0, 13'h0022);
    cm(`CMD_MRS, 2'h2, 13'h0155);
    cm(`CMD_MRS, 2'h1, 13'h1fff);
    host_model_inst.cmd(`CMD_MRS | 4'h8, 2'h0, 13'h0777, 1'b0, 1'b1);
    nx(0);
    chk(13'h0022, mode_reg_r);
    chk(13'h0155, ext_mode_reg_r);
    host_model_inst.cmd(`CMD_MRS, 2'h0, 13'h0032, 1'b1, 1'b1);
    nx(0);
    chk(13'h0032, mode_reg_r);
  endtask
  task automatic t_burst;
    logic [2:0] bl [5] = '{`BL_1, `BL_2, `BL_4, `BL_8, `BL_PAGE};
    int len [5] = '{1, 2, 4, 8, 30};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      cm(`CMD_MRS, 2'h0, {6'h00, 3'h3, 1'b0, bl[i]});
      cm(`CMD_ACT, 2'h0, 13'h0100);
      cm(`CMD_RD, 2'h0, 13'h0000);
      n = 0;
      nx(0);
      while (burst_active_r === 1'b1 && n < 30)
      begin
        n++;
        @(negedge clk);
      end
      chk(len[i], n);
      cm(`CMD_BST, 2'h0, 13'h0000);
      nx(0);
      chk(13'h0000, burst_active_r);
      cm(`CMD_PRE, 2'h0, 13'h0400);
    end
    cm(`CMD_MRS, 2'h0, 13'h0032);
  endtask
  task automatic t_read;
    cm(`CMD_ACT, 2'h1, 13'h1abc);
    nx(0);
    chk(13'h0002, bank_open_r);
    chk(13'h1abc, access_row_r);
    cm(`CMD_RD, 2'h1, 13'h0c05);
    nx(0);
    chk(13'h0405, access_col_r);
    chk(13'h0001, auto_precharge_r);
    chk(13'h0001, access_bank_r);
    host_model_inst.lvl(1'b1, 8'h0f, 1'b0);
    nx(2);
    chk(13'h0000, read_drive_en_r[3:0]);
    host_model_inst.lvl(1'b1, 8'h00, 1'b0);
    nx(6);
    chk(13'h0000, bank_open_r);
  endtask
  task automatic t_write;
    host_model_inst.lvl(1'b1, 8'ha5, 1'b0);
    cm(`CMD_ACT, 2'h2, 13'h0007);
    cm(`CMD_WR, 2'h2, 13'h0010);
    nx(0);
    chk(13'h0001, burst_is_write_r);
    nx(1);
    chk(13'h005a, write_lane_en_r);
    host_model_inst.lvl(1'b0, 8'ha5, 1'b0);
    nx(1);
    chk(13'h0001, clock_suspend_r);
    host_model_inst.lvl(1'b1, 8'h00, 1'b0);
    nx(8);
    cm(`CMD_ACT, 2'h0, 13'h0009);
    cm(`CMD_PRE, 2'h2, 13'h0000);
    nx(0);
    chk(13'h0001, bank_open_r);
    cm(`CMD_PRE, 2'h3, 13'h0400);
    nx(0);
    chk(13'h0000, bank_open_r);
  endtask
  task automatic t_pwr;
    cm(`CMD_REF, 2'h0, 13'h0000);
    nx(0);
    chk(13'h0001, refresh_pulse_r);
    nx(1);
    chk(13'h0000, refresh_pulse_r);
    host_model_inst.lvl(1'b0, 8'h00, 1'b0);
    nx(1);
    chk(13'h0001, power_down_r);
    chk(13'h0000, input_buf_en);
    host_model_inst.cmd(`CMD_ACT, 2'h0, 13'h0001, 1'b0, 1'b0);
    nx(0);
    chk(13'h0000, bank_open_r);
    host_model_inst.lvl(1'b1, 8'h00, 1'b0);
    nx(1);
    chk(13'h0000, power_down_r);
    host_model_inst.cmd(`CMD_REF, 2'h0, 13'h0000, 1'b0, 1'b0);
    nx(1);
    chk(13'h0001, self_refresh_r);
    host_model_inst.lvl(1'b1, 8'h00, 1'b0);
    nx(1);
    chk(13'h0000, self_refresh_r);
    chk(13'h0001, input_buf_en);
  endtask
  task automatic t_reg;
    host_model_inst.lvl(1'b1, 8'h00, 1'b1);
    cm(`CMD_ACT, 2'h3, 13'h0005);
    nx(0);
    chk(13'h0000, bank_open_r);
    nx(1);
    chk(13'h0008, bank_open_r);
    cm(`CMD_PRE, 2'h0, 13'h0400);
    nx(1);
    chk(13'h0000, bank_open_r);
    host_model_inst.lvl(1'b1, 8'h00, 1'b0);
    cm(`CMD_RD, 2'h3, 13'h0000);
    nx(0);
    chk(13'h0001, protocol_err_r);
  endtask
  // ==========================================
  // Sequence and watchdog
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_mrs;
    t_burst;
    t_read;
    t_write;
    t_pwr;
    t_reg;
    end_of_test;
  end
  initial
  begin
    #20000;
    error_cnt++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
